//--- pes_event_select.v
// APB-programmed event selection and counter routing for three performance events
`timescale 1ns/1ns
`include "pes_regs.vh"

// Function
// - Retired branch, third/fourth selector feeds fixed counters
// - Mispredict counted with select 03H, config 04H
// - Mispredict needs mask bit0 and non-speculative retire
// - Mispredict first/second selector feeds fixed counters
// - Trace mode counts every cycle mode holds
// - Trace mode select 01H, any set mask
// - Trace mode feeds counters 4,5 or 6,7
// - Trace mask bits pick processor mode pairs
// - Branch counts any set outcome mask bit
module pes_event_select #(
  parameter NUM_CNT = `PES_NUM_CNT
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`PES_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire retire_valid,
  input wire retire_branch,
  input wire retire_taken,
  input wire retire_mispred,
  input wire retire_non_speculative,
  input wire [1:0] lp0_mode,
  input wire [1:0] lp1_mode,
  output reg [NUM_CNT-1:0] cnt_inc
);
  wire [`PES_IDX_W-1:0] widx = paddr[`PES_ADDR_W-1:2];
  wire [`PES_IDX_W-1:0] coff = widx - `PES_CFG_IDX_BASE;
  wire wr_en = psel & penable & pwrite;
  wire rd_setup = psel & ~penable;

  reg [1:0] ctrl_q;
  wire [32*`PES_NUM_SEL-1:0] sel_flat;
  wire [`PES_CFG_W*NUM_CNT-1:0] cfg_flat;
  wire [NUM_CNT-1:0] inc_d;
  wire [`PES_NUM_SEL-1:0] hit_mis;
  wire [`PES_NUM_SEL-1:0] hit_br;
  wire [`PES_NUM_SEL-1:0] hit_tc;
  wire global_en = ctrl_q[`PES_CTRL_GEN_BIT];
  reg [31:0] rdata_d;
  reg err_d;

  // Zero wait states: read data is latched in the setup cycle
  assign pready = 1'b1;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `PES_CTRL_RST;
    end else if (wr_en && widx == `PES_CTRL_IDX) begin
      ctrl_q <= pwdata[1:0];
    end
  end

  genvar i;
  generate
    for (i = 0; i < `PES_NUM_SEL; i = i + 1) begin : g_sel
      localparam integer IDX_I = `PES_SEL_IDX_BASE + i;
      localparam [`PES_IDX_W-1:0] MY_IDX = IDX_I[`PES_IDX_W-1:0];
      reg [31:0] sel_q;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sel_q <= `PES_SEL_RST;
        end else if (wr_en && widx == MY_IDX) begin
          sel_q <= pwdata & `PES_SEL_WMASK;
        end
      end
      assign sel_flat[32*i +: 32] = sel_q;
      pes_event_qual u_qual (
        .sel_word(sel_q),
        .single_lp(ctrl_q[`PES_CTRL_SLP_BIT]),
        .retire_valid(retire_valid),
        .retire_branch(retire_branch),
        .retire_taken(retire_taken),
        .retire_mispred(retire_mispred),
        .retire_non_speculative(retire_non_speculative),
        .lp0_mode(lp0_mode),
        .lp1_mode(lp1_mode),
        .hit_mispred(hit_mis[i]),
        .hit_branch(hit_br[i]),
        .hit_trace(hit_tc[i])
      );
    end
  endgenerate

  // Counters without a route keep no configuration and never step
  genvar n;
  generate
    for (n = 0; n < NUM_CNT; n = n + 1) begin : g_cnt
      localparam integer IDX_I = `PES_CFG_IDX_BASE + n;
      localparam [`PES_IDX_W-1:0] MY_IDX = IDX_I[`PES_IDX_W-1:0];
      if ((n >= 12 && n <= 17) || (n >= 4 && n <= 7)) begin : g_live
        reg [`PES_CFG_W-1:0] cfg_q;
        wire [2:0] csel = cfg_q[2:0];
        wire cen = cfg_q[3];
        always @(posedge pclk or negedge presetn) begin
          if (!presetn) begin
            cfg_q <= `PES_CFG_RST;
          end else if (wr_en && widx == MY_IDX) begin
            cfg_q <= {pwdata[`PES_CEN_BIT], pwdata[`PES_CSEL_HI:`PES_CSEL_LO]};
          end
        end
        assign cfg_flat[`PES_CFG_W*n +: `PES_CFG_W] = cfg_q;
        if (n >= 12) begin : g_ret
          // 12, 13, 16 hang on the first selector of a pair; 14, 15, 17 on the second
          localparam integer B = (n == 14 || n == 15 || n == 17) ? 1 : 0;
          assign inc_d[n] = global_en && cen &&
            ((csel == `PES_CS_MISPRED && hit_mis[`PES_RET_A_IDX + B]) ||
             (csel == `PES_CS_BRANCH && hit_br[`PES_RET_C_IDX + B]));
        end else begin : g_trc
          localparam integer B = (n >= 6) ? 1 : 0;
          assign inc_d[n] = global_en && cen && csel == `PES_CS_TRACE &&
                            hit_tc[`PES_TRC_A_IDX + B];
        end
      end else begin : g_none
        assign cfg_flat[`PES_CFG_W*n +: `PES_CFG_W] = `PES_CFG_RST;
        assign inc_d[n] = 1'b0;
      end
    end
  endgenerate

  // One registered step pulse per counter, one cycle after the qualifying event
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_inc <= {NUM_CNT{1'b0}};
    end else begin
      cnt_inc <= inc_d;
    end
  end

  always @* begin
    rdata_d = 32'h0000_0000;
    err_d = 1'b0;
    if (widx < `PES_SEL_IDX_BASE + `PES_NUM_SEL) begin
      rdata_d = sel_flat[32*widx[2:0] +: 32];
    end else if (widx == `PES_CTRL_IDX) begin
      rdata_d = {30'h0000_0000, ctrl_q};
    end else if (widx == `PES_STATUS_IDX) begin
      rdata_d = {{(32-NUM_CNT){1'b0}}, cnt_inc};
    end else if (widx >= `PES_CFG_IDX_BASE && coff < NUM_CNT) begin
      // Stored as {enable, select}; put each back at its own field on read
      rdata_d[`PES_CSEL_HI:`PES_CSEL_LO] = cfg_flat[`PES_CFG_W*coff[4:0] +: 3];
      rdata_d[`PES_CEN_BIT] = cfg_flat[`PES_CFG_W*coff[4:0] + 3];
    end else begin
      err_d = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (rd_setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rdata_d;
      pslverr <= err_d;
    end
  end
endmodule // pes_event_select

//--- pes_regs.vh
// Register map, field layout and event codes of the performance event selector
`ifndef PES_REGS_VH
`define PES_REGS_VH

`define PES_ADDR_W 12
`define PES_IDX_W 10
`define PES_NUM_SEL 6
`define PES_NUM_CNT 18
`define PES_CFG_W 4

// Word indices; byte address is four times the index
`define PES_SEL_IDX_BASE 10'h000
`define PES_RET_A_IDX 3'h0
`define PES_RET_B_IDX 3'h1
`define PES_RET_C_IDX 3'h2
`define PES_RET_D_IDX 3'h3
`define PES_TRC_A_IDX 3'h4
`define PES_TRC_B_IDX 3'h5
`define PES_CTRL_IDX 10'h008
`define PES_STATUS_IDX 10'h00c
`define PES_CFG_IDX_BASE 10'h010

// Event selection register fields
`define PES_EVSEL_HI 31
`define PES_EVSEL_LO 25
`define PES_MASK_HI 24
`define PES_MASK_LO 9
`define PES_SEL_RST 32'h0000_0000
`define PES_SEL_WMASK 32'hffff_fe00

// Counter configuration register fields
`define PES_CSEL_HI 15
`define PES_CSEL_LO 13
`define PES_CEN_BIT 12
`define PES_CFG_RST 4'h0

// Control register fields
`define PES_CTRL_GEN_BIT 0
`define PES_CTRL_SLP_BIT 1
`define PES_CTRL_RST 2'h0

// Event select codes
`define PES_EV_MISPRED 7'h03
`define PES_EV_BRANCH 7'h06
`define PES_EV_TRACE 7'h01

// Counter configuration select codes
`define PES_CS_MISPRED 3'h4
`define PES_CS_BRANCH 3'h5
`define PES_CS_TRACE 3'h1

// Mask bit positions within the event mask field
`define PES_MB_NON_SPEC 0
`define PES_MB_NTP 0
`define PES_MB_NTM 1
`define PES_MB_TP 2
`define PES_MB_TM 3
`define PES_NUM_TMODE 8

// Logical processor operating mode codes
`define PES_MODE_DELIVER 2'h0
`define PES_MODE_BUILD 2'h1
`define PES_MODE_IDLE 2'h2
`define PES_MODE_COUNT 2'h3

`endif

//--- pes_event_qual.v
// Event qualification for one event selection register
`timescale 1ns/1ns
`include "pes_regs.vh"

module pes_event_qual (
  input wire [31:0] sel_word,
  input wire single_lp,
  input wire retire_valid,
  input wire retire_branch,
  input wire retire_taken,
  input wire retire_mispred,
  input wire retire_non_speculative,
  input wire [1:0] lp0_mode,
  input wire [1:0] lp1_mode,
  output reg hit_mispred,
  output reg hit_branch,
  output reg hit_trace
);
  wire [6:0] evsel = sel_word[`PES_EVSEL_HI:`PES_EVSEL_LO];
  wire [15:0] mask = sel_word[`PES_MASK_HI:`PES_MASK_LO];
  wire br_ret = retire_valid & retire_branch;
  // A package with one logical processor reports the second one as halted
  wire [1:0] lp1_eff = single_lp ? `PES_MODE_IDLE : lp1_mode;
  reg [3:0] br_class;
  reg [`PES_NUM_TMODE-1:0] tmode;
  integer k;

  always @* begin
    br_class = 4'h0;
    tmode = {`PES_NUM_TMODE{1'b0}};
    br_class[`PES_MB_NTP] = br_ret & ~retire_taken & ~retire_mispred;
    br_class[`PES_MB_NTM] = br_ret & ~retire_taken & retire_mispred;
    br_class[`PES_MB_TP] = br_ret & retire_taken & ~retire_mispred;
    br_class[`PES_MB_TM] = br_ret & retire_taken & retire_mispred;
    // Bit index is lp0 mode times three plus lp1 mode; both idle has no mask bit
    for (k = 0; k < `PES_NUM_TMODE; k = k + 1) begin
      tmode[k] = (lp0_mode != `PES_MODE_COUNT) && (lp1_eff != `PES_MODE_COUNT) &&
                 ({2'h0, lp0_mode} * 4'h3 + {2'h0, lp1_eff} == k[3:0]);
    end
    hit_mispred = (evsel == `PES_EV_MISPRED) && mask[`PES_MB_NON_SPEC] &&
                  br_ret && retire_mispred && retire_non_speculative;
    hit_branch = (evsel == `PES_EV_BRANCH) && |(mask[3:0] & br_class);
    hit_trace = (evsel == `PES_EV_TRACE) &&
                |(mask[`PES_NUM_TMODE-1:0] & tmode);
  end
endmodule // pes_event_qual

//--- pes_sel_checker.sv
// Port assertions for the event selector
`timescale 1ns/1ns
module pes_sel_checker #(
  parameter NUM_CNT = 18
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire retire_valid,
  input wire retire_branch,
  input wire [1:0] lp0_mode,
  input wire [1:0] lp1_mode,
  input wire [NUM_CNT-1:0] cnt_inc
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_route; cnt_inc[3:0] == 4'h0 && cnt_inc[11:8] == 4'h0; endproperty
  a_route: assert property (p_route) else $error("unrouted step");
  property p_ret; |cnt_inc[17:12] |-> $past(retire_valid) && $past(retire_branch); endproperty
  a_ret: assert property (p_ret) else $error("retire step without branch");
  property p_tmode; |cnt_inc[7:4] |-> $past(lp0_mode) != 2'h3; endproperty
  a_tmode: assert property (p_tmode) else $error("trace step in no mode");
  property p_tidle; |cnt_inc[7:4] |-> !($past(lp0_mode) == 2'h2 && $past(lp1_mode) == 2'h2);
  endproperty
  a_tidle: assert property (p_tidle) else $error("trace step both idle");
  // Config may only change through an access, so a quiet bus plus steady modes must keep counting
  property p_hold;
    cnt_inc[4] && !psel && !$past(psel) && $stable(lp0_mode) && $stable(lp1_mode) |=> cnt_inc[4];
  endproperty
  a_hold: assert property (p_hold) else $error("duration count broke");
  property p_err; psel && !penable && paddr == 12'h018 |=> pslverr; endproperty
  a_err: assert property (p_err) else $error("unmapped not refused");
  property p_rsvd; psel && !penable && !pwrite && paddr < 12'h018 |=> prdata[8:0] == 9'h000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("low selector bits set");
  property p_stat; psel && !penable && !pwrite && paddr == 12'h030 |=> prdata[17:0] == $past(cnt_inc);
  endproperty
  a_stat: assert property (p_stat) else $error("status mismatch");
  c_mis: cover property (cnt_inc[12]);
  c_hold: cover property (cnt_inc[4] [*4]);
  c_err: cover property (pslverr && penable);
endmodule // pes_sel_checker
bind pes_event_select pes_sel_checker #(.NUM_CNT(NUM_CNT)) u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pslverr(pslverr), .retire_valid(retire_valid),
  .retire_branch(retire_branch), .lp0_mode(lp0_mode), .lp1_mode(lp1_mode), .cnt_inc(cnt_inc));

//--- pes_pipe_model.sv
// Retirement and trace-mode source for the selector's event inputs
`timescale 1ns/1ns
module pes_pipe_model (
  input wire pclk,
  input wire [8:0] stim,
  output reg retire_valid = 1'b0,
  output reg retire_branch = 1'b0,
  output reg retire_taken = 1'b0,
  output reg retire_mispred = 1'b0,
  output reg retire_non_speculative = 1'b0,
  output reg [1:0] lp0_mode = 2'h0,
  output reg [1:0] lp1_mode = 2'h0
);
  // Registered so pipeline state only moves just after an edge
  always @(posedge pclk)
    {retire_valid, retire_branch, retire_taken, retire_mispred, retire_non_speculative,
      lp0_mode, lp1_mode} <= stim;
endmodule // pes_pipe_model

//--- pes_event_select_test.sv
// Random and corner-case bench for the event selector
`timescale 1ns/1ns
`include "pes_regs.vh"
module pes_event_select_test;
  reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg gen = 1'b0, slp = 1'b0, e;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0000_0000, r, d;
  reg [8:0] stim = 9'h000;
  reg [17:0] exp_q = 18'h0_0000;
  reg [31:0] esc [0:5];
  reg [3:0] cfg [0:17];
  wire [31:0] prdata;
  wire [17:0] cnt_inc;
  wire pready, pslverr, rv, rb, rtk, rm, rn;
  wire [1:0] l0, l1;
  integer seed = 78, n_errors = 0, n_compared = 0, i, k, n;
  pes_pipe_model model (.pclk(pclk), .stim(stim), .retire_valid(rv), .retire_branch(rb),
    .retire_taken(rtk), .retire_mispred(rm), .retire_non_speculative(rn), .lp0_mode(l0),
    .lp1_mode(l1));
  pes_event_select dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .retire_valid(rv), .retire_branch(rb), .retire_taken(rtk),
    .retire_mispred(rm), .retire_non_speculative(rn), .lp0_mode(l0), .lp1_mode(l1),
    .cnt_inc(cnt_inc));
  initial forever #5 pclk = ~pclk;
  function [17:0] f(input [8:0] s);
    reg [17:0] m;
    reg [15:0] mk;
    reg [1:0] l1e;
    reg h;
    integer j, c;
    begin
      f = 18'h0_0000;
      l1e = slp ? 2'h2 : s[1:0];
      for (j = 0; j < 6; j++) begin
        mk = esc[j][24:9];
        if (j < 2) h = esc[j][31:25] == 7'h03 && mk[0] && s[8] && s[7] && s[5] && s[4];
        else if (j < 4) h = esc[j][31:25] == 7'h06 && s[8] && s[7] && mk[s[6:5]];
        else h = esc[j][31:25] == 7'h01 && s[3:2] != 2'h3 && l1e != 2'h3
          && s[3:2] * 3 + l1e < 8
          && mk[s[3:2] * 3 + l1e];
        m = j == 4 ? 18'h0_0030 : j == 5 ? 18'h0_00c0 : j % 2 ? 18'h2_c000 : 18'h1_3000;
        for (c = 0; c < 18; c++)
          if (h && gen && m[c] && cfg[c] == {1'b1, j < 2 ? 3'h4 : j < 4 ? 3'h5 : 3'h1}) f[c] = 1'b1;
      end
    end
  endfunction
  task chk(input [31:0] a, input [31:0] b);
    n_compared++;
    if (a !== b) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, a, b);
    end
  endtask
  always @(posedge pclk)
    if (!presetn) exp_q <= 18'h0_0000;
    else begin
      chk(cnt_inc, exp_q);
      exp_q <= f({rv, rb, rtk, rm, rn, l0, l1});
    end
  task xfer(input w, input [11:0] a, input [31:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input [11:0] a, input [31:0] v);
    xfer(1'b1, a, v);
    if (a < 12'h018) esc[a[4:2]] <= v & `PES_SEL_WMASK;
    if (a == 12'h020) {slp, gen} <= v[1:0];
    if (a >= 12'h040 && a < 12'h088) cfg[(a - 12'h040) >> 2] <= {v[12], v[15:13]};
  endtask
  task summarize;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    #500000;
    n_errors++;
    summarize;
  end
  initial begin
    for (i = 0; i < 18; i++) begin
      cfg[i] = 4'h0;
      if (i < 6) esc[i] = 32'h0000_0000;
    end
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 6; i++) xfer(1'b0, i * 4, 32'h0000_0000);
    chk(r, 32'h0000_0000);
    xfer(1'b0, 12'h018, 32'h0000_0000);
    chk(e, 1'b1);
    wr(12'h030, 32'hffff_ffff);
    chk(e, 1'b0);
    for (k = 0; k < 12; k++) begin
      for (i = 0; i < 6; i++) begin
        d = $random(seed);
        if (k < 4) d[31:9] = {i < 2 ? 7'h03 : i < 4 ? 7'h06 : 7'h01, k ? 16'hffff : 16'h0000};
        else d[31:25] = {4'h0, d[27:25]};
        wr(i * 4, d);
        xfer(1'b0, i * 4, 32'h0000_0000);
        chk(r, d & `PES_SEL_WMASK);
      end
      for (n = 0; n < 18; n++) begin
        d = $random(seed);
        if (k < 4) d[15:12] = {n < 8 ? 3'h1 : k == 1 ? 3'h4 : 3'h5, 1'b1};
        wr(12'h040 + n * 4, d);
      end
      xfer(1'b0, 12'h084, 32'h0000_0000);
      chk(r, d & 32'h0000_f000);
      // Odd passes run one logical processor; pass 2 checks the global gate
      wr(12'h020, {30'h0, k % 2 == 1, k != 2});
      repeat (40) begin
        @(posedge pclk);
        d = $random(seed);
        stim <= k == 3 ? 9'h1f1 : d[8:0];
      end
      xfer(1'b0, 12'h030, 32'h0000_0000);
    end
    // Reset in mid-run must clear the configuration registers; only counter 17's, at 084H, is read back
    presetn <= 1'b0;
    {slp, gen} <= 2'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, 12'h084, 32'h0000_0000);
    chk(r, 32'h0000_0000);
    summarize;
  end
endmodule // pes_event_select_test
